// *** design/kwit_pkg.sv ***
// Package of constants, types and decode helpers for the keyed watchdog interval timer
// Operation
// - Run bit low halts counting and keeps the count; it resets to zero.
// - Range bit low: low prescale bits pick clock over 2^5 to 2^12.
// - Range bit high: low bits pick 2^14,16,17,18,19,21,23 or 25.
// - Range bit clear keeps the legacy three-bit prescale meaning unchanged.
// - Extension register clears only on power-on, survives watchdog-caused reset.
// - Protected registers take only 16-bit writes; byte and long writes ignored.
// - Counter write carries key 5A above the new count byte.
// - Control write carries key A5 above the data byte.
// - Extension write carries key AA above the data byte.
// - Watchdog mode overflow sets its flag, fires selected reset, keeps counting.
// - Interval mode overflow sets its flag, requests interrupt, keeps counting.
// - Mode bit zero selects interval mode, one watchdog; reset gives interval.
// - Reset-kind bit picks reset type in watchdog mode; ignored otherwise.
// - Interval flag set only by interval-mode overflow; reset clears it. The code also lets a keyed control write set it.
// - Watchdog flag set only by watchdog-mode overflow; power-on reset clears it, watchdog-caused reset does not. A keyed control write also sets it.
package kwit_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0]  KWIT_OFS_COUNT   = 8'h08;
   localparam logic [7:0]  KWIT_OFS_CTRL    = 8'h0C;
   localparam logic [7:0]  KWIT_OFS_EXT     = 8'h10;

   localparam logic [7:0]  KWIT_KEY_COUNT   = 8'h5A;
   localparam logic [7:0]  KWIT_KEY_CTRL    = 8'hA5;
   localparam logic [7:0]  KWIT_KEY_EXT     = 8'hAA;

   localparam logic [1:0]  KWIT_SIZE_BYTE   = 2'h0;
   localparam logic [1:0]  KWIT_SIZE_WORD   = 2'h1;
   localparam logic [1:0]  KWIT_SIZE_LONG   = 2'h2;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int          KWIT_BIT_RUN     = 7;
   localparam int          KWIT_BIT_MODE    = 6;
   localparam int          KWIT_BIT_KIND    = 5;
   localparam int          KWIT_BIT_WDOG_OVERFLOW_FLAG    = 4;
   localparam int          KWIT_BIT_INTERVAL_OVERFLOW_FLAG    = 3;
   localparam int          KWIT_BIT_PRESC   = 0;
   localparam int          KWIT_BIT_RANGE   = 0;

   localparam logic [7:0]  KWIT_CTRL_RESET  = 8'h00;
   localparam logic [7:0]  KWIT_EXT_RESET   = 8'h00;
   localparam logic [7:0]  KWIT_COUNT_RESET = 8'h00;
   localparam logic [7:0]  KWIT_COUNT_MAX   = 8'hFF;

   // ****************************************************************
   // Divider exponents, index {range, low bits}
   // ****************************************************************
   localparam int          KWIT_DIV_BITS    = 25;
   localparam logic [15:0][4:0] KWIT_EXP_TABLE = {
      5'h19, 5'h17, 5'h15, 5'h13, 5'h12, 5'h11, 5'h10, 5'h0E,
      5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05};

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [1:0]  size;
      logic        wr;
      logic        rd;
   } kwit_bus_req_t;

   typedef struct packed {
      logic req;
      logic kind;
   } kwit_reset_t;

   // ****************************************************************
   // Decode helpers
   // ****************************************************************
   function automatic logic keyed_write(input kwit_bus_req_t req,
                                        input logic [7:0]    ofs,
                                        input logic [7:0]    key);
      keyed_write = req.wr && (req.addr == ofs) && (req.size == KWIT_SIZE_WORD)
                    && (req.wdata[15:8] == key);
   endfunction : keyed_write

   function automatic logic [4:0] div_exponent(input logic       range,
                                               input logic [2:0] low);
      div_exponent = KWIT_EXP_TABLE[{range, low}];
   endfunction : div_exponent

endpackage : kwit_pkg

// *** design/kwit_prescaler.sv ***
// Prescaler that turns the peripheral clock into count ticks
`timescale 1ns/1ps
module kwit_prescaler
   import kwit_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Control
   input  wire logic       run,
   input  wire logic [3:0] select,
   // Tick out
   output logic            tick
);

   import kwit_pkg::*;

   logic [KWIT_DIV_BITS-1:0] divCount;
   logic [15:0]              hit;

   // Divider restarts from zero while stopped so every start has a known phase
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         divCount <= '0;
      end else if (!run) begin
         divCount <= '0;
      end else begin
         divCount <= divCount + 1'b1;
      end
   end

   // One tap per selectable ratio
   for (genvar i = 0; i < 16; i++) begin : g_tap
      localparam int E = int'(KWIT_EXP_TABLE[i]);
      assign hit[i] = &divCount[E-1:0];
   end

   assign tick = run && hit[select];

endmodule : kwit_prescaler

// *** design/kwit_top.sv ***
// Keyed watchdog and interval timer with register port
`timescale 1ns/1ps
module kwit_top
   import kwit_pkg::*;
(
   // Clock and power-on reset
   input  wire logic                 clock,
   input  wire logic                 reset,
   // Chip reset caused by this block, fed back by the reset unit
   input  wire logic                 internalReset,
   // Register port
   input  wire kwit_pkg::kwit_bus_req_t busReq,
   output logic [31:0]               readData,
   // Events
   output logic                      intervalIrq,
   output kwit_pkg::kwit_reset_t     wdogReset
);

   import kwit_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   logic [7:0] count;
   logic       runBit;
   logic       modeBit;
   logic       kindBit;
   logic       wdog_overflow_flag;
   logic       interval_overflow_flag;
   logic [2:0] presLow;
   logic       rangeBit;

   logic       tick;
   logic       overflow;
   logic       wrCount;
   logic       wrCtrl;
   logic       wrExt;
   logic       next_wdog_overflow_flag;
   logic       next_interval_overflow_flag;
   logic [7:0] ctrlView;
   logic [7:0] extView;

   // ****************************************************************
   // Write decode
   // ****************************************************************
   // Byte and long writes, or a wrong key, never match
   assign wrCount = keyed_write(busReq, KWIT_OFS_COUNT, KWIT_KEY_COUNT);
   assign wrCtrl  = keyed_write(busReq, KWIT_OFS_CTRL, KWIT_KEY_CTRL);
   assign wrExt   = keyed_write(busReq, KWIT_OFS_EXT, KWIT_KEY_EXT);

   // ****************************************************************
   // Prescaler
   // ****************************************************************
   kwit_prescaler u_prescaler (
      .clock  (clock),
      .reset  (reset),
      .run    (runBit),
      .select ({rangeBit, presLow}),
      .tick   (tick)
   );

   // ****************************************************************
   // Counter
   // ****************************************************************
   assign overflow = tick && (count == KWIT_COUNT_MAX);

   // A bus write in the same cycle as a tick wins; software reload is the
   // whole point of servicing, so it must never be lost to a step.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         count <= KWIT_COUNT_RESET;
      end else if (internalReset) begin
         count <= KWIT_COUNT_RESET;
      end else if (wrCount) begin
         count <= busReq.wdata[7:0];
      end else if (tick) begin
         count <= count + 8'h01;
      end
   end

   // ****************************************************************
   // Control fields
   // ****************************************************************
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         runBit  <= KWIT_CTRL_RESET[KWIT_BIT_RUN];
         modeBit <= KWIT_CTRL_RESET[KWIT_BIT_MODE];
         kindBit <= KWIT_CTRL_RESET[KWIT_BIT_KIND];
         presLow <= KWIT_CTRL_RESET[KWIT_BIT_PRESC +: 3];
      end else if (internalReset) begin
         runBit  <= KWIT_CTRL_RESET[KWIT_BIT_RUN];
         modeBit <= KWIT_CTRL_RESET[KWIT_BIT_MODE];
         kindBit <= KWIT_CTRL_RESET[KWIT_BIT_KIND];
         presLow <= KWIT_CTRL_RESET[KWIT_BIT_PRESC +: 3];
      end else if (wrCtrl) begin
         runBit  <= busReq.wdata[KWIT_BIT_RUN];
         modeBit <= busReq.wdata[KWIT_BIT_MODE];
         kindBit <= busReq.wdata[KWIT_BIT_KIND];
         presLow <= busReq.wdata[KWIT_BIT_PRESC +: 3];
      end
   end

   // ****************************************************************
   // Overflow flags
   // ****************************************************************
   // Hardware set wins over a software clear in the same cycle
   always_comb begin
      next_wdog_overflow_flag = wrCtrl ? busReq.wdata[KWIT_BIT_WDOG_OVERFLOW_FLAG] : wdog_overflow_flag;
      next_interval_overflow_flag = wrCtrl ? busReq.wdata[KWIT_BIT_INTERVAL_OVERFLOW_FLAG] : interval_overflow_flag;
      if (overflow && modeBit) begin
         next_wdog_overflow_flag = 1'b1;
      end
      if (overflow && !modeBit) begin
         next_interval_overflow_flag = 1'b1;
      end
   end

   // The watchdog flag survives the reset it caused so software can see why
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wdog_overflow_flag <= KWIT_CTRL_RESET[KWIT_BIT_WDOG_OVERFLOW_FLAG];
      end else begin
         wdog_overflow_flag <= next_wdog_overflow_flag;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         interval_overflow_flag <= KWIT_CTRL_RESET[KWIT_BIT_INTERVAL_OVERFLOW_FLAG];
      end else if (internalReset) begin
         interval_overflow_flag <= KWIT_CTRL_RESET[KWIT_BIT_INTERVAL_OVERFLOW_FLAG];
      end else begin
         interval_overflow_flag <= next_interval_overflow_flag;
      end
   end

   // ****************************************************************
   // Extension register
   // ****************************************************************
   // Only the power-on reset touches it; the fed-back chip reset does not
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rangeBit <= KWIT_EXT_RESET[KWIT_BIT_RANGE];
      end else if (wrExt) begin
         rangeBit <= busReq.wdata[KWIT_BIT_RANGE];
      end
   end

   // ****************************************************************
   // Event outputs
   // ****************************************************************
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wdogReset <= '0;
      end else begin
         wdogReset.req  <= overflow && modeBit;
         wdogReset.kind <= modeBit ? kindBit : 1'b0;
      end
   end

   // Interrupt request is a level for as long as the interval flag stands
   assign intervalIrq = interval_overflow_flag;

   // ****************************************************************
   // Read port
   // ****************************************************************
   always_comb begin
      ctrlView = KWIT_CTRL_RESET;
      ctrlView[KWIT_BIT_RUN]       = runBit;
      ctrlView[KWIT_BIT_MODE]      = modeBit;
      ctrlView[KWIT_BIT_KIND]      = kindBit;
      ctrlView[KWIT_BIT_WDOG_OVERFLOW_FLAG]      = wdog_overflow_flag;
      ctrlView[KWIT_BIT_INTERVAL_OVERFLOW_FLAG]      = interval_overflow_flag;
      ctrlView[KWIT_BIT_PRESC +: 3] = presLow;
      extView = KWIT_EXT_RESET;
      extView[KWIT_BIT_RANGE]      = rangeBit;
   end

   // Data stand only in the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         readData <= '0;
      end else if (busReq.rd) begin
         unique case (busReq.addr)
            KWIT_OFS_COUNT: readData <= {24'h00_0000, count};
            KWIT_OFS_CTRL:  readData <= {24'h00_0000, ctrlView};
            KWIT_OFS_EXT:   readData <= {24'h00_0000, extView};
            default:        readData <= '0;
         endcase
      end else begin
         readData <= '0;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   // Tick spacing watcher: counts cycles between ticks at a steady selection
   logic [25:0] gapCount;
   logic        gapValid;
   logic [3:0]  lastSel;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         gapCount <= '0;
         gapValid <= 1'b0;
         lastSel  <= 4'h0;
      end else begin
         lastSel <= {rangeBit, presLow};
         if (!runBit || (lastSel != {rangeBit, presLow})) begin
            gapCount <= '0;
            gapValid <= 1'b0;
         end else if (tick) begin
            gapCount <= 26'h000_0001;
            gapValid <= 1'b1;
         end else begin
            gapCount <= gapCount + 26'h000_0001;
         end
      end
   end

   AST_RUN_HOLDS: assert property (
      !runBit && !wrCount && !internalReset |=> count == $past(count))
      else $error("Count moved while stopped");

   AST_TICK_GAP: assert property (
      tick && gapValid && (lastSel == {rangeBit, presLow}) && runBit
      |-> gapCount == (26'h000_0001 << div_exponent(rangeBit, presLow)))
      else $error("Tick spacing does not match selected ratio");

   AST_LEGACY: assert property (
      !rangeBit |-> div_exponent(rangeBit, presLow) == 5'({2'h0, presLow} + 5'h05))
      else $error("Legacy prescale meaning changed");

   AST_EXT_KEEP: assert property (
      internalReset && !wrExt |=> rangeBit == $past(rangeBit))
      else $error("Extension register lost on internal reset");

   AST_SIZE_ONLY: assert property (
      busReq.wr && (busReq.addr == KWIT_OFS_CTRL) && (busReq.size != KWIT_SIZE_WORD)
      && !internalReset |=> $stable(presLow) && $stable(modeBit) && $stable(runBit))
      else $error("Non-word write changed control");

   AST_COUNT_KEY: assert property (
      wrCount && !internalReset |=> count == $past(busReq.wdata[7:0]))
      else $error("Keyed counter write not stored");

   AST_CTRL_KEY: assert property (
      wrCtrl && !internalReset
      |=> presLow == $past(busReq.wdata[2:0]) && runBit == $past(busReq.wdata[7]))
      else $error("Keyed control write not stored");

   AST_EXT_KEY: assert property (
      wrExt |=> rangeBit == $past(busReq.wdata[0]))
      else $error("Keyed extension write not stored");

   AST_BAD_KEY: assert property (
      busReq.wr && (busReq.addr == KWIT_OFS_EXT) && (busReq.size == KWIT_SIZE_WORD)
      && (busReq.wdata[15:8] != KWIT_KEY_EXT) |=> $stable(rangeBit))
      else $error("Wrong key changed extension register");

   AST_WDOG_OVF: assert property (
      overflow && modeBit && !internalReset
      |=> wdog_overflow_flag && wdogReset.req && wdogReset.kind == $past(kindBit) && !$rose(interval_overflow_flag))
      else $error("Watchdog overflow not handled");

   AST_INT_OVF: assert property (
      overflow && !modeBit && !internalReset
      |=> interval_overflow_flag && intervalIrq && !wdogReset.req && !$rose(wdog_overflow_flag))
      else $error("Interval overflow not handled");

   AST_WRAP: assert property (
      overflow && !wrCount && !internalReset |=> count == 8'h00)
      else $error("Counter did not wrap to zero");

   AST_STEP: assert property (
      tick && (count != KWIT_COUNT_MAX) && !wrCount && !internalReset
      |=> count == $past(count) + 8'h01)
      else $error("Counter did not step by one");

   AST_KIND_IGNORED: assert property (
      !modeBit |=> !wdogReset.req)
      else $error("Reset issued in interval mode");

   AST_READ_SLOT: assert property (
      !busReq.rd |=> readData == 32'h0000_0000)
      else $error("Read data outside its slot");

   AST_STOP_NO_TICK: assert property (
      !runBit |-> !tick)
      else $error("Tick seen while stopped");

   AST_REQ_PULSE: assert property (
      wdogReset.req |=> !wdogReset.req)
      else $error("Watchdog reset request longer than one cycle");

   AST_KIND_ZERO: assert property (
      !modeBit |=> !wdogReset.kind)
      else $error("Reset kind driven in interval mode");

   // Flags move only by their own overflow, a keyed write or a reset
   AST_WDOG_OVERFLOW_FLAG_STICKY: assert property (
      wdog_overflow_flag && !wrCtrl |=> wdog_overflow_flag)
      else $error("Watchdog flag cleared without a write");

   AST_INTERVAL_OVERFLOW_FLAG_STICKY: assert property (
      interval_overflow_flag && !wrCtrl && !internalReset |=> interval_overflow_flag)
      else $error("Interval flag cleared without a write");

   AST_WDOG_OVERFLOW_FLAG_MODE: assert property (
      !modeBit && !wrCtrl |=> !$rose(wdog_overflow_flag))
      else $error("Watchdog flag set in interval mode");

   AST_INTERVAL_OVERFLOW_FLAG_MODE: assert property (
      modeBit && !wrCtrl |=> !$rose(interval_overflow_flag))
      else $error("Interval flag set in watchdog mode");

   AST_EXT_SIZE: assert property (
      busReq.wr && (busReq.addr == KWIT_OFS_EXT) && (busReq.size != KWIT_SIZE_WORD)
      |=> $stable(rangeBit))
      else $error("Non-word write changed extension register");

   AST_COUNT_SIZE: assert property (
      busReq.wr && (busReq.addr == KWIT_OFS_COUNT) && !wrCount && !tick && !internalReset
      |=> $stable(count))
      else $error("Unkeyed or non-word write changed counter");

   AST_INT_RESET: assert property (
      internalReset |=> !runBit && !modeBit && !interval_overflow_flag && count == KWIT_COUNT_RESET)
      else $error("Internal reset left state behind");

   AST_READ_COUNT: assert property (
      busReq.rd && (busReq.addr == KWIT_OFS_COUNT)
      |=> readData == {24'h00_0000, $past(count)})
      else $error("Counter read returned wrong value");

   COV_WDOG: cover property (overflow && modeBit ##1 wdogReset.req);
   COV_INTERVAL: cover property (overflow && !modeBit ##1 intervalIrq);
   COV_EXT_TICK: cover property (rangeBit && tick);
   COV_BAD_KEY: cover property (busReq.wr && busReq.size == KWIT_SIZE_WORD
                                && !wrCount && !wrCtrl && !wrExt);
   COV_INT_RESET: cover property (internalReset && rangeBit && wdog_overflow_flag);

endmodule : kwit_top

// *** bench/kwit_top_bench.sv ***
// Self-checking bench for the keyed watchdog and interval timer
`timescale 1ns/1ps
module kwit_top_bench;
   import kwit_pkg::*;

   // ****************************************************************
   // Signals
   // ****************************************************************
   logic          clock;
   logic          reset;
   logic          internalReset;
   kwit_bus_req_t busReq;
   logic [31:0]   readData;
   logic          intervalIrq;
   kwit_reset_t   wdogReset;
   int            errorCnt;
   int            totalChecks;
   int            reqCnt = 0;
   int            n;
   int            k;

   kwit_top dut_u (
      .clock         (clock),
      .reset         (reset),
      .internalReset (internalReset),
      .busReq        (busReq),
      .readData      (readData),
      .intervalIrq   (intervalIrq),
      .wdogReset     (wdogReset)
   );

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Counts watchdog reset pulses so that interval phases can prove none fired
   always @(posedge clock) begin
      if (wdogReset.req === 1'b1) begin
         reqCnt <= reqCnt + 1;
      end
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         errorCnt++;
         $display("ERROR at %0t: saw 0x%08h, expected 0x%08h", $time, seen, exp);
      end
   endtask : check

   task automatic bus_write(input logic [7:0] ofs, input logic [7:0] key,
                            input logic [7:0] data, input logic [1:0] size);
      @(posedge clock);
      busReq.addr  <= ofs;
      busReq.wdata <= {16'h0000, key, data};
      busReq.size  <= size;
      busReq.wr    <= 1'b1;
      @(posedge clock);
      busReq.wr    <= 1'b0;
   endtask : bus_write

   // Byte-size read; data stand only in the cycle after the strobe
   task automatic rd_check(input logic [7:0] ofs, input logic [31:0] exp);
      @(posedge clock);
      busReq.addr <= ofs;
      busReq.size <= KWIT_SIZE_BYTE;
      busReq.rd   <= 1'b1;
      @(posedge clock);
      busReq.rd   <= 1'b0;
      #1;
      check(readData, exp);
   endtask : rd_check

   task automatic key_test(input logic [7:0] ofs, input logic [7:0] key,
                           input logic [7:0] good, input logic [7:0] bad,
                           input logic [7:0] exp);
      bus_write(ofs, key, good, KWIT_SIZE_WORD);
      rd_check(ofs, {24'h00_0000, exp});
      bus_write(ofs, key, bad, KWIT_SIZE_BYTE);
      bus_write(ofs, key, bad, KWIT_SIZE_LONG);
      bus_write(ofs, ~key, bad, KWIT_SIZE_WORD);
      rd_check(ofs, {24'h00_0000, exp});
   endtask : key_test

   task automatic test_done(input string name);
      $display("Test %s finished, %0d mismatches so far", name, errorCnt);
   endtask : test_done

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   // ****************************************************************
   // Watchdog of the run
   // ****************************************************************
   initial begin
      repeat (95000) @(posedge clock);
      errorCnt++;
      $display("ERROR at %0t: run did not finish in time", $time);
      conclude();
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      busReq        = '0;
      internalReset = 1'b0;
      reset         = 1'b1;
      errorCnt      = 0;
      totalChecks   = 0;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      rd_check(KWIT_OFS_CTRL, 32'h0000_0000);
      rd_check(KWIT_OFS_COUNT, 32'h0000_0000);
      rd_check(KWIT_OFS_EXT, 32'h0000_0000);
      rd_check(8'h04, 32'h0000_0000);
      @(posedge clock);
      #1;
      check(readData, 32'h0000_0000);
      test_done("reset values");

      key_test(KWIT_OFS_COUNT, KWIT_KEY_COUNT, 8'h3C, 8'hC3, 8'h3C);
      key_test(KWIT_OFS_CTRL, KWIT_KEY_CTRL, 8'h67, 8'h05, 8'h67);
      key_test(KWIT_OFS_EXT, KWIT_KEY_EXT, 8'hFF, 8'h00, 8'h01);
      test_done("keyed writes");

      // Nine ratios: legacy range fully, extended range at its cheapest entry
      for (int i = 0; i < 9; i++) begin
         n = (i < 8) ? 5 + i : 14;
         bus_write(KWIT_OFS_CTRL, KWIT_KEY_CTRL, 8'h00, KWIT_SIZE_WORD);
         bus_write(KWIT_OFS_COUNT, KWIT_KEY_COUNT, 8'h00, KWIT_SIZE_WORD);
         bus_write(KWIT_OFS_EXT, KWIT_KEY_EXT, {7'h00, i == 8}, KWIT_SIZE_WORD);
         bus_write(KWIT_OFS_CTRL, KWIT_KEY_CTRL, {5'h10, i[2:0]}, KWIT_SIZE_WORD);
         // Sample mid-way between the second and third tick
         repeat ((2 << n) + (1 << (n - 1))) @(posedge clock);
         rd_check(KWIT_OFS_COUNT, 32'h0000_0002);
         bus_write(KWIT_OFS_CTRL, KWIT_KEY_CTRL, 8'h00, KWIT_SIZE_WORD);
         repeat (64) @(posedge clock);
         rd_check(KWIT_OFS_COUNT, 32'h0000_0002);
      end
      bus_write(KWIT_OFS_EXT, KWIT_KEY_EXT, 8'h00, KWIT_SIZE_WORD);
      test_done("prescale and run");

      bus_write(KWIT_OFS_CTRL, KWIT_KEY_CTRL, 8'h20, KWIT_SIZE_WORD);
      bus_write(KWIT_OFS_COUNT, KWIT_KEY_COUNT, 8'hFE, KWIT_SIZE_WORD);
      bus_write(KWIT_OFS_CTRL, KWIT_KEY_CTRL, 8'hA0, KWIT_SIZE_WORD);
      for (k = 0; k < 200; k++) begin
         @(posedge clock);
         #1;
         if (intervalIrq === 1'b1) break;
      end
      check({31'h0000_0000, intervalIrq}, 32'h0000_0001);
      check({31'h0000_0000, wdogReset.kind}, 32'h0000_0000);
      rd_check(KWIT_OFS_CTRL, 32'h0000_00A8);
      repeat (48) @(posedge clock);
      rd_check(KWIT_OFS_COUNT, 32'h0000_0001);
      check(32'(reqCnt), 32'h0000_0000);
      bus_write(KWIT_OFS_CTRL, KWIT_KEY_CTRL, 8'hA0, KWIT_SIZE_WORD);
      #1;
      check({31'h0000_0000, intervalIrq}, 32'h0000_0000);
      bus_write(KWIT_OFS_CTRL, KWIT_KEY_CTRL, 8'h20, KWIT_SIZE_WORD);
      test_done("interval mode");

      bus_write(KWIT_OFS_CTRL, KWIT_KEY_CTRL, 8'h40, KWIT_SIZE_WORD);
      bus_write(KWIT_OFS_CTRL, KWIT_KEY_CTRL, 8'h60, KWIT_SIZE_WORD);
      bus_write(KWIT_OFS_COUNT, KWIT_KEY_COUNT, 8'hF0, KWIT_SIZE_WORD);
      bus_write(KWIT_OFS_CTRL, KWIT_KEY_CTRL, 8'hE0, KWIT_SIZE_WORD);
      // Feeding faster than 16 ticks keeps the count far from all ones
      repeat (5) begin
         repeat (100) @(posedge clock);
         bus_write(KWIT_OFS_COUNT, KWIT_KEY_COUNT, 8'h00, KWIT_SIZE_WORD);
      end
      check(32'(reqCnt), 32'h0000_0000);
      bus_write(KWIT_OFS_COUNT, KWIT_KEY_COUNT, 8'hFD, KWIT_SIZE_WORD);
      for (k = 0; k < 200; k++) begin
         @(posedge clock);
         #1;
         if (wdogReset.req === 1'b1) break;
      end
      check({31'h0000_0000, wdogReset.req}, 32'h0000_0001);
      check({31'h0000_0000, wdogReset.kind}, 32'h0000_0001);
      @(posedge clock);
      #1;
      check({31'h0000_0000, wdogReset.req}, 32'h0000_0000);
      rd_check(KWIT_OFS_CTRL, 32'h0000_00F0);
      check({31'h0000_0000, intervalIrq}, 32'h0000_0000);
      // Reset kind may change while running, and so may prescale and mode
      bus_write(KWIT_OFS_CTRL, KWIT_KEY_CTRL, 8'hC0, KWIT_SIZE_WORD);
      bus_write(KWIT_OFS_COUNT, KWIT_KEY_COUNT, 8'hFF, KWIT_SIZE_WORD);
      for (k = 0; k < 200; k++) begin
         @(posedge clock);
         #1;
         if (wdogReset.req === 1'b1) break;
      end
      check({31'h0000_0000, wdogReset.req}, 32'h0000_0001);
      check({31'h0000_0000, wdogReset.kind}, 32'h0000_0000);
      test_done("watchdog mode");

      bus_write(KWIT_OFS_CTRL, KWIT_KEY_CTRL, 8'h50, KWIT_SIZE_WORD);
      bus_write(KWIT_OFS_EXT, KWIT_KEY_EXT, 8'h01, KWIT_SIZE_WORD);
      bus_write(KWIT_OFS_COUNT, KWIT_KEY_COUNT, 8'h5A, KWIT_SIZE_WORD);
      @(posedge clock);
      internalReset <= 1'b1;
      @(posedge clock);
      internalReset <= 1'b0;
      rd_check(KWIT_OFS_CTRL, 32'h0000_0010);
      rd_check(KWIT_OFS_EXT, 32'h0000_0001);
      rd_check(KWIT_OFS_COUNT, 32'h0000_0000);
      @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      rd_check(KWIT_OFS_EXT, 32'h0000_0000);
      rd_check(KWIT_OFS_CTRL, 32'h0000_0000);
      test_done("reset kinds");
      conclude();
   end

endmodule : kwit_top_bench
